// [rtl/mbf_framer.v]
// modbus serial frame receive, gap timing, master poll and log output
`timescale 1ns/1ps
`include "mbf_defs.vh"

module mbf_framer #(
	parameter [7:0]            RX_DEPTH  = 8'd253,
	parameter [`MBF_TMR_W-1:0] ASC_GAP   = `MBF_ASCII_GAP_CYC,
	parameter [`MBF_TMR_W-1:0] RTU_CHAR  = `MBF_RTU_CHAR_CYC,
	parameter [`MBF_TMR_W-1:0] RTU_REST  = `MBF_RTU_REST_CYC,
	parameter [`MBF_TMR_W-1:0] POLL_CYC  = `MBF_POLL_CYC,
	parameter                  LOG_DEPTH = 16
) (
	// clock and reset
	input  wire        mclk,
	input  wire        nrst,
	// configuration
	input  wire        cfg_master,
	input  wire        cfg_ascii,
	input  wire [7:0]  node_addr,
	// bus serial port, received characters
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	// bus serial port, characters to send
	output wire        tx_valid,
	input  wire        tx_ready,
	output reg  [7:0]  tx_data,
	// frame handler
	output reg         req_call,
	output reg         resp_call,
	output reg         gap_err,
	output reg  [7:0]  rx_result,
	output reg  [7:0]  frm_len,
	input  wire [7:0]  frm_rd_idx,
	output reg  [7:0]  frm_rd_data,
	// log serial port
	output wire        log_valid,
	input  wire        log_ready,
	output wire [7:0]  log_data
);

	// ****************************************
	// constants and helpers
	// ****************************************
	localparam [4:0] TX_IDLE = 5'b00001;
	localparam [4:0] TX_SOM  = 5'b00010;
	localparam [4:0] TX_DAT  = 5'b00100;
	localparam [4:0] TX_EOM1 = 5'b01000;
	localparam [4:0] TX_EOM2 = 5'b10000;
	localparam [`MBF_TMR_W-1:0] T0 = 0;
	localparam [`MBF_TMR_W-1:0] T1 = 1;
	localparam [15:0]           POLL_START = `MBF_POLL_START;
	localparam [15:0]           POLL_QTY   = `MBF_POLL_QTY;
	localparam [7:0]            RES_GAP    = `MBF_RES_GAP;

	function [15:0] crc_upd;
		input [15:0] c;
		input [7:0]  b;
		integer      i;
		reg   [15:0] t;
		begin
			t = c ^ {8'h00, b};
			for (i = 0; i < 8; i = i + 1)
				t = t[0] ? ((t >> 1) ^ `MBF_CRC_POLY) : (t >> 1);
			crc_upd = t;
		end
	endfunction

	// bit 4 marks a valid hex digit
	function [4:0] hex_val;
		input [7:0] c;
		reg   [7:0] t;
		begin
			t = 8'h00;
			if (c >= 8'h30 && c <= 8'h39)
				t = c - 8'h30;
			else if (c >= 8'h41 && c <= 8'h46)
				t = c - 8'h37;
			else if (c >= 8'h61 && c <= 8'h66)
				t = c - 8'h57;
			hex_val = {(c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
				|| (c >= 8'h61 && c <= 8'h66), t[3:0]};
		end
	endfunction

	function [7:0] hex_chr;
		input [3:0] n;
		hex_chr = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	function fc_ok;
		input [7:0] f;
		case (f)
			8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h17: fc_ok = 1'b1;
			default: fc_ok = 1'b0;
		endcase
	endfunction

	function [7:0] pay;
		input [2:0] i;
		case (i)
			3'd0:    pay = `MBF_POLL_ADDR;
			3'd1:    pay = `MBF_FC_READ_COILS;
			3'd2:    pay = POLL_START[15:8];
			3'd3:    pay = POLL_START[7:0];
			3'd4:    pay = POLL_QTY[15:8];
			default: pay = POLL_QTY[7:0];
		endcase
	endfunction

	// ****************************************
	// receive path and gap timer
	// ****************************************
	reg  [7:0]            buf_q [0:RX_DEPTH-1];
	reg  [7:0]            rx_cnt_q;
	reg                   in_frm_q;
	reg                   cr_q;
	reg                   nib_hi_q;
	reg  [3:0]            nib_q;
	reg                   gap_on_q;
	reg                   gap_pend_q;
	reg  [`MBF_TMR_W-1:0] gap_cnt_q;
	reg                   frm_rx_q;
	reg  [15:0]           crc_q;
	reg  [7:0]            lrc_q;
	reg  [7:0]            res;

	// characters are ignored for the one cycle in which a frame is checked
	wire       rx_ok    = rx_valid & !frm_rx_q;
	wire [7:0] ach      = {1'b0, rx_data[6:0]};
	wire [4:0] hv       = hex_val(ach);
	wire       gap_exp  = gap_on_q && (gap_cnt_q == T0);
	wire       a_som    = cfg_ascii & rx_ok & (ach == `MBF_CH_COLON);
	wire       a_in     = cfg_ascii & rx_ok & in_frm_q & !a_som;
	wire       a_end    = a_in & cr_q & (ach == `MBF_CH_LF);
	wire       a_hex    = a_in & !cr_q & hv[4];
	wire       a_cr     = a_in & !cr_q & (ach == `MBF_CH_CR);
	wire       a_bad    = a_in & !a_end & !a_hex & !a_cr;
	wire       a_gap    = cfg_ascii & gap_exp & in_frm_q & !a_in;
	wire       r_err    = !cfg_ascii & rx_ok & gap_pend_q;
	wire       r_chr    = !cfg_ascii & rx_ok & !gap_pend_q;
	wire       r_exp1   = !cfg_ascii & gap_exp & !gap_pend_q & !r_chr;
	wire       r_exp2   = !cfg_ascii & gap_exp & gap_pend_q & !r_err;
	wire       gap_ev   = a_gap | r_err;
	wire       store    = (a_hex & nib_hi_q) | r_chr;
	wire [7:0] st_byte  = cfg_ascii ? {nib_q, hv[3:0]} : rx_data;
	wire       done     = a_end | r_exp2;
	wire       restart  = r_chr | a_som | (a_in & !a_end & !a_bad);
	wire       clr      = a_som | gap_ev | a_bad | frm_rx_q;
	wire       sum_ok   = cfg_ascii ? (lrc_q == 8'h00) : (crc_q == 16'h0000);
	wire       call_ok  = frm_rx_q & (res == `MBF_RES_OK);

	always @*
	begin
		res = `MBF_RES_OK;
		if (rx_cnt_q < (cfg_ascii ? `MBF_MIN_ASC : `MBF_MIN_RTU))
			res = `MBF_RES_LEN;
		else if (buf_q[0] != (cfg_master ? `MBF_POLL_ADDR : node_addr))
			res = `MBF_RES_NOT_ME;
		else if (!fc_ok(buf_q[1] & 8'h7F))
			res = `MBF_RES_ILL_FN;
		else if (!sum_ok)
			res = `MBF_RES_CHKSUM;
		else if (cfg_master & buf_q[1][7])
			res = `MBF_RES_ERR_RESP;
	end

	always @(posedge mclk)
	begin
		if (store && rx_cnt_q < RX_DEPTH)
			buf_q[rx_cnt_q] <= st_byte;
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_cnt_q    <= 8'h00;
			in_frm_q    <= 1'b0;
			cr_q        <= 1'b0;
			nib_hi_q    <= 1'b0;
			nib_q       <= 4'h0;
			gap_on_q    <= 1'b0;
			gap_pend_q  <= 1'b0;
			gap_cnt_q   <= T0;
			frm_rx_q    <= 1'b0;
			crc_q       <= `MBF_CRC_INIT;
			lrc_q       <= 8'h00;
			req_call    <= 1'b0;
			resp_call   <= 1'b0;
			gap_err     <= 1'b0;
			rx_result   <= `MBF_RES_NONE;
			frm_len     <= 8'h00;
			frm_rd_data <= 8'h00;
		end
		else
		begin
			frm_rd_data <= (frm_rd_idx < RX_DEPTH) ? buf_q[frm_rd_idx] : 8'h00;
			req_call    <= call_ok & !cfg_master;
			resp_call   <= call_ok & cfg_master;
			gap_err     <= gap_ev;
			if (frm_rx_q)
			begin
				rx_result <= res;
				frm_len   <= rx_cnt_q;
				frm_rx_q  <= 1'b0;
			end
			if (gap_ev)
				rx_result <= `MBF_RES_GAP;
			// one counter serves both stages
			if (restart)
			begin
				gap_on_q  <= 1'b1;
				gap_cnt_q <= (cfg_ascii ? ASC_GAP : RTU_CHAR) - T1;
			end
			else if (r_exp1)
				gap_cnt_q <= RTU_REST - T1;
			else if (done | gap_ev | a_bad | gap_exp)
				gap_on_q <= 1'b0;
			else if (gap_on_q)
				gap_cnt_q <= gap_cnt_q - T1;
			if (r_exp1)
				gap_pend_q <= 1'b1;
			else if (r_exp2 | r_err)
				gap_pend_q <= 1'b0;
			if (clr)
			begin
				rx_cnt_q <= 8'h00;
				crc_q    <= `MBF_CRC_INIT;
				lrc_q    <= 8'h00;
			end
			else if (store && rx_cnt_q < RX_DEPTH)
			begin
				rx_cnt_q <= rx_cnt_q + 8'h01;
				crc_q    <= crc_upd(crc_q, st_byte);
				lrc_q    <= lrc_q + st_byte;
			end
			if (a_som)
				in_frm_q <= 1'b1;
			else if (a_end | a_gap | a_bad)
				in_frm_q <= 1'b0;
			if (a_cr)
				cr_q <= 1'b1;
			else if (a_som | a_end | a_bad | a_gap)
				cr_q <= 1'b0;
			if (a_som)
				nib_hi_q <= 1'b0;
			else if (a_hex)
			begin
				nib_hi_q <= !nib_hi_q;
				nib_q    <= hv[3:0];
			end
			if (done)
				frm_rx_q <= 1'b1;
		end
	end

	// ****************************************
	// master poll timer and request sender
	// ****************************************
	reg  [`MBF_TMR_W-1:0] poll_cnt_q;
	reg  [4:0]            st_q;
	reg  [4:0]            st_d;
	reg  [2:0]            idx_q;
	reg  [2:0]            idx_d;
	reg                   nib_s_q;
	reg                   nib_s_d;
	reg  [15:0]           tcrc_q;
	reg  [15:0]           tcrc_d;
	reg  [7:0]            tlrc_q;
	reg  [7:0]            tlrc_d;
	reg  [7:0]            tx_data_d;
	reg                   sent;
	reg  [7:0]            tb;

	wire poll_due = cfg_master && (poll_cnt_q == POLL_CYC - T1);
	wire tx_last  = (idx_q == (cfg_ascii ? 3'd6 : 3'd7));

	assign tx_valid = (st_q != TX_IDLE);

	always @*
	begin
		st_d    = st_q;
		idx_d   = idx_q;
		nib_s_d = nib_s_q;
		tcrc_d  = tcrc_q;
		tlrc_d  = tlrc_q;
		sent    = 1'b0;
		case (st_q)
			TX_IDLE:
				if (poll_due)
				begin
					tcrc_d  = `MBF_CRC_INIT;
					tlrc_d  = 8'h00;
					idx_d   = 3'd0;
					nib_s_d = 1'b0;
					st_d    = cfg_ascii ? TX_SOM : TX_DAT;
				end
			TX_SOM:
				if (tx_ready)
					st_d = TX_DAT;
			TX_DAT:
				if (tx_ready)
				begin
					if (cfg_ascii & !nib_s_q)
						nib_s_d = 1'b1;
					else
					begin
						nib_s_d = 1'b0;
						if (idx_q < 3'd6)
						begin
							tcrc_d = crc_upd(tcrc_q, pay(idx_q));
							tlrc_d = tlrc_q + pay(idx_q);
						end
						idx_d = idx_q + 3'd1;
						if (tx_last)
						begin
							st_d = cfg_ascii ? TX_EOM1 : TX_IDLE;
							sent = !cfg_ascii;
						end
					end
				end
			TX_EOM1:
				if (tx_ready)
					st_d = TX_EOM2;
			TX_EOM2:
				if (tx_ready)
				begin
					st_d = TX_IDLE;
					sent = 1'b1;
				end
			default:
				st_d = TX_IDLE;
		endcase
		// character of the next position, so tx_data comes from a flop
		if (idx_d < 3'd6)
			tb = pay(idx_d);
		else if (cfg_ascii)
			tb = 8'h00 - tlrc_d;
		else if (idx_d == 3'd6)
			tb = tcrc_d[7:0];
		else
			tb = tcrc_d[15:8];
		case (st_d)
			TX_SOM:  tx_data_d = `MBF_CH_COLON;
			TX_EOM1: tx_data_d = `MBF_CH_CR;
			TX_EOM2: tx_data_d = `MBF_CH_LF;
			TX_DAT:  tx_data_d = cfg_ascii ? hex_chr(nib_s_d ? tb[3:0] : tb[7:4]) : tb;
			default: tx_data_d = 8'h00;
		endcase
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			poll_cnt_q <= T0;
			st_q       <= TX_IDLE;
			idx_q      <= 3'd0;
			nib_s_q    <= 1'b0;
			tcrc_q     <= `MBF_CRC_INIT;
			tlrc_q     <= 8'h00;
			tx_data    <= 8'h00;
		end
		else
		begin
			// a poll falling due while a request is still going out is skipped
			if (!cfg_master || poll_due)
				poll_cnt_q <= T0;
			else
				poll_cnt_q <= poll_cnt_q + T1;
			st_q    <= st_d;
			idx_q   <= idx_d;
			nib_s_q <= nib_s_d;
			tcrc_q  <= tcrc_d;
			tlrc_q  <= tlrc_d;
			tx_data <= tx_data_d;
		end
	end

	// ****************************************
	// log records
	// ****************************************
	reg  [31:0] lg_rec_q;
	reg  [2:0]  lg_n_q;
	wire        lg_ready;
	wire        lg_valid = (lg_n_q != 3'd0);

	// one record in flight; an event arriving meanwhile is not logged
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			lg_rec_q <= 32'h00000000;
			lg_n_q   <= 3'd0;
		end
		else if (lg_valid)
		begin
			if (lg_ready)
			begin
				lg_rec_q <= {lg_rec_q[23:0], 8'h00};
				lg_n_q   <= lg_n_q - 3'd1;
			end
		end
		else if (frm_rx_q)
		begin
			lg_rec_q <= {`MBF_LOG_RX, res[3:0], rx_cnt_q, buf_q[0], buf_q[1]};
			lg_n_q   <= 3'd4;
		end
		else if (gap_ev)
		begin
			lg_rec_q <= {`MBF_LOG_ERR, RES_GAP[3:0], rx_cnt_q, 16'h0000};
			lg_n_q   <= 3'd4;
		end
		else if (sent)
		begin
			lg_rec_q <= {`MBF_LOG_TX, 4'h1, cfg_ascii ? 8'h11 : 8'h08,
				`MBF_POLL_ADDR, `MBF_FC_READ_COILS};
			lg_n_q   <= 3'd4;
		end
	end

	mbf_fifo #(
		.W  (8),
		.D  (LOG_DEPTH),
		.AW (4)
	) u_log_fifo (
		.mclk      (mclk),
		.nrst      (nrst),
		.in_valid  (lg_valid),
		.in_ready  (lg_ready),
		.in_data   (lg_rec_q[31:24]),
		.out_valid (log_valid),
		.out_ready (log_ready),
		.out_data  (log_data)
	);

endmodule // mbf_framer

// [shared/mbf_defs.vh]
// shared constants of the serial frame timing block
`ifndef MBF_DEFS_VH
`define MBF_DEFS_VH

// ****************************************
// clock and timing
// ****************************************
`define MBF_CLK_MHZ 25
`define MBF_TMR_W 25
`define MBF_US2CYC(us) ((us) * `MBF_CLK_MHZ)
// 1.5 chars x 11 bits / 19200 baud x 1.01, in microseconds
`define MBF_RTU_CHAR_US 868
// 3.5 chars x 11 bits / 19200 baud x 1.01, in microseconds
`define MBF_RTU_FRAME_US 2026
`define MBF_RTU_REST_US (`MBF_RTU_FRAME_US - `MBF_RTU_CHAR_US)
`define MBF_ASCII_GAP_US 1000000
`define MBF_POLL_US 1000000
`define MBF_RTU_CHAR_CYC `MBF_US2CYC(`MBF_RTU_CHAR_US)
`define MBF_RTU_REST_CYC `MBF_US2CYC(`MBF_RTU_REST_US)
`define MBF_ASCII_GAP_CYC `MBF_US2CYC(`MBF_ASCII_GAP_US)
`define MBF_POLL_CYC `MBF_US2CYC(`MBF_POLL_US)

// ****************************************
// ascii framing characters
// ****************************************
`define MBF_CH_COLON 8'h3A
`define MBF_CH_CR 8'h0D
`define MBF_CH_LF 8'h0A

// ****************************************
// master poll request
// ****************************************
`define MBF_POLL_ADDR 8'h01
`define MBF_FC_READ_COILS 8'h01
`define MBF_POLL_START 16'h0000
`define MBF_POLL_QTY 16'h0010

// ****************************************
// checksums and lengths
// ****************************************
`define MBF_CRC_INIT 16'hFFFF
`define MBF_CRC_POLY 16'hA001
`define MBF_MIN_RTU 8'h04
`define MBF_MIN_ASC 8'h03

// ****************************************
// receive results
// ****************************************
`define MBF_RES_NONE 8'h00
`define MBF_RES_OK 8'h01
`define MBF_RES_NOT_ME 8'h03
`define MBF_RES_ILL_FN 8'h04
`define MBF_RES_CHKSUM 8'h05
`define MBF_RES_GAP 8'h06
`define MBF_RES_LEN 8'h07
`define MBF_RES_ERR_RESP 8'h08

// ****************************************
// log record tags
// ****************************************
`define MBF_LOG_RX 4'hA
`define MBF_LOG_TX 4'hB
`define MBF_LOG_ERR 4'hE

`endif

// [rtl/mbf_fifo.v]
// small flop based fifo with valid and ready on both sides
`timescale 1ns/1ps

module mbf_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	// clock and reset
	input  wire          mclk,
	input  wire          nrst,
	// filling side
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	// draining side
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);

	// depth must be a power of two so the pointers wrap by themselves
	localparam [AW:0] DEPTH_N = D;
	localparam [AW-1:0] P1 = 1;
	localparam [AW:0] C1 = 1;

	reg  [W-1:0]  mem_q [0:D-1];
	reg  [AW-1:0] wr_q;
	reg  [AW-1:0] rd_q;
	reg  [AW:0]   cnt_q;
	wire          push;
	wire          pop;

	assign in_ready  = (cnt_q != DEPTH_N);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge mclk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + P1;
			if (pop)
				rd_q <= rd_q + P1;
			if (push & !pop)
				cnt_q <= cnt_q + C1;
			else if (pop & !push)
				cnt_q <= cnt_q - C1;
		end
	end

endmodule // mbf_fifo

// [tb/mbf_framer_assertions.sv]
// port assertions of the serial frame timing block
`timescale 1ns/1ps

module mbf_framer_assertions #(
	parameter [24:0] ASC_GAP  = 25'h28,
	parameter [24:0] RTU_CHAR = 25'h14,
	parameter [24:0] RTU_REST = 25'h1E
) (
	// clock and reset
	input wire       mclk,
	input wire       nrst,
	// mode
	input wire       cfg_master,
	input wire       cfg_ascii,
	// bus side
	input wire       rx_valid,
	input wire       tx_valid,
	input wire       tx_ready,
	input wire [7:0] tx_data,
	// handler and log side
	input wire       req_call,
	input wire       resp_call,
	input wire       gap_err,
	input wire [7:0] rx_result,
	input wire       log_valid,
	input wire       log_ready,
	input wire [7:0] log_data
);
	// silence since the latest character, saturating
	logic [31:0] quiet_q;
	logic [31:0] quiet_d;
	always @*
		quiet_d = rx_valid ? 32'h0 : quiet_q + {31'h0, quiet_q != 32'hFFFFFFFF};
	always @(posedge mclk or negedge nrst)
		if (!nrst)
			quiet_q <= 32'h0;
		else
			quiet_q <= quiet_d;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_rtu_frame_end:
		assert property ((req_call || resp_call) && !cfg_ascii |->
			quiet_q >= RTU_CHAR + RTU_REST && quiet_q <= RTU_CHAR + RTU_REST + 3)
		else $error("rtu call off the frame gap");
	a_ascii_frame_end:
		assert property ((req_call || resp_call) && cfg_ascii |-> quiet_q >= 1 && quiet_q <= 3)
		else $error("ascii call not right after line feed");
	a_ascii_gap_time:
		assert property (gap_err && cfg_ascii |-> quiet_q + 1 >= ASC_GAP && quiet_q <= ASC_GAP + 2)
		else $error("ascii gap error off the timeout");
	a_rtu_gap_char:
		assert property (gap_err && !cfg_ascii |-> quiet_q <= 1)
		else $error("rtu gap error without a late character");
	a_gap_result:
		assert property (gap_err |-> ##[0:1] rx_result == 8'h06)
		else $error("gap error without gap result");
	a_call_result:
		assert property (req_call || resp_call |-> ##[0:1] rx_result == 8'h01)
		else $error("call without ok result");
	a_slave_call:
		assert property (req_call |-> !cfg_master)
		else $error("request call in master mode");
	a_master_call:
		assert property (resp_call |-> cfg_master)
		else $error("response call in slave mode");
	a_poll_master:
		assert property (tx_valid |-> cfg_master)
		else $error("transmit in slave mode");
	a_tx_hold:
		assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("transmit character dropped before taken");
	a_log_hold:
		assert property (log_valid && !log_ready |=> log_valid && $stable(log_data))
		else $error("log byte dropped before taken");
endmodule // mbf_framer_assertions

bind mbf_framer mbf_framer_assertions #(.ASC_GAP(ASC_GAP), .RTU_CHAR(RTU_CHAR),
	.RTU_REST(RTU_REST)) mbf_framer_assertions_inst (.mclk(mclk), .nrst(nrst),
	.cfg_master(cfg_master), .cfg_ascii(cfg_ascii), .rx_valid(rx_valid),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .req_call(req_call),
	.resp_call(resp_call), .gap_err(gap_err), .rx_result(rx_result),
	.log_valid(log_valid), .log_ready(log_ready), .log_data(log_data));

// [tb/mbf_bus_node.sv]
// behavioural far-side bus node feeding and draining the framer
`timescale 1ns/1ps

module mbf_bus_node (
	// clock
	input  wire        mclk,
	// characters toward the framer
	output logic       rx_valid,
	output logic [7:0] rx_data,
	// characters from the framer
	input  wire        tx_valid,
	output logic       tx_ready,
	input  wire [7:0]  tx_data,
	// pacing
	input  wire        slow
);
	logic [7:0] tx_seen[$];
	logic [1:0] ph;
	initial
	begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
		ph       = 2'h0;
	end
	// one character, then idle cycles of silence
	task automatic put(input logic [7:0] c, input int idle);
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_data  = c;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_data  = ~c; // stale data must not pass for the last char
		repeat (idle) @(negedge mclk);
	endtask
	// slow mode stalls three cycles of four
	always @(negedge mclk)
	begin
		ph       <= ph + 2'h1;
		tx_ready <= slow ? (ph == 2'h3) : 1'b1;
	end
	always @(posedge mclk)
		if (tx_valid && tx_ready)
			tx_seen.push_back(tx_data);
endmodule // mbf_bus_node

// [tb/mbf_framer_bench.sv]
// self-checking bench of the serial frame timing block
`timescale 1ns/1ps

`define CMP(g, e, m) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %0t %s", $time, m); end end

module mbf_framer_bench;
	localparam [24:0] CG = 25'h14, CR = 25'h1E, AG = 25'h28, PC = 25'h190;
	logic       mclk, nrst, cfg_master, cfg_ascii, log_ready, slow;
	logic       rx_valid, tx_valid, tx_ready, req_call, resp_call, gap_err, log_valid;
	logic [7:0] node_addr, frm_rd_idx, rx_data, tx_data, rx_result, frm_len;
	logic [7:0] frm_rd_data, log_data;
	logic [7:0] frm[$];
	logic [7:0] wire_q[$];
	logic [7:0] logq[$];
	int         err_total, comparisons, calls, gaps, cyc;

	mbf_framer #(.ASC_GAP(AG), .RTU_CHAR(CG), .RTU_REST(CR), .POLL_CYC(PC)) mbf_framer_inst (
		.mclk(mclk), .nrst(nrst), .cfg_master(cfg_master), .cfg_ascii(cfg_ascii),
		.node_addr(node_addr), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .req_call(req_call), .resp_call(resp_call),
		.gap_err(gap_err), .rx_result(rx_result), .frm_len(frm_len), .frm_rd_idx(frm_rd_idx),
		.frm_rd_data(frm_rd_data), .log_valid(log_valid), .log_ready(log_ready),
		.log_data(log_data));
	mbf_bus_node mbf_bus_node_inst (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .slow(slow));

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		calls += (req_call | resp_call);
		gaps += gap_err;
		if (log_valid && log_ready)
			logq.push_back(log_data);
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] hx(input logic [3:0] n);
		return n < 4'hA ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	// wire image of frm: crc for rtu, colon/hex/lrc/cr/lf for ascii
	function automatic void mk_wire(input logic a);
		logic [15:0] c;
		logic [7:0]  s;
		c = 16'hFFFF;
		s = 8'h00;
		foreach (frm[i])
		begin
			s = s - frm[i];
			c = c ^ {8'h00, frm[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		if (a)
		begin
			wire_q = {8'h3A};
			foreach (frm[i]) wire_q = {wire_q, hx(frm[i][7:4]), hx(frm[i][3:0])};
			wire_q = {wire_q, hx(s[7:4]), hx(s[3:0]), 8'h0D, 8'h0A};
		end
		else
			wire_q = {frm, c[7:0], c[15:8]};
	endfunction
	task automatic send_frm(input logic a, input logic [7:0] flip);
		mk_wire(a);
		wire_q[$] = wire_q[$] ^ flip;
		foreach (wire_q[i]) mbf_bus_node_inst.put(wire_q[i], 2);
	endtask
	task automatic do_reset(input logic m, input logic a);
		@(negedge mclk);
		nrst = 1'b0;
		cfg_master = m;
		cfg_ascii = a;
		repeat (5) @(negedge mclk);
		nrst = 1'b1;
		logq.delete();
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_rtu_slave();
		int n0;
		do_reset(1'b0, 1'b0);
		`CMP({tx_valid, req_call, gap_err, log_valid, rx_result}, 12'h000, "reset state");
		n0 = calls;
		frm = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
		send_frm(1'b0, 8'h00);
		repeat (CG + CR + 4) @(negedge mclk);
		`CMP({calls - n0 == 1, rx_result, frm_len}, 17'h10108, "rtu frame");
		frm_rd_idx = 8'h05;
		repeat (2) @(negedge mclk);
		`CMP(frm_rd_data, 8'h01, "stored byte");
		`CMP({logq[0], logq[1], logq[2], logq[3]}, 32'hA1080101, "rx log");
		foreach (frm[i]) mbf_bus_node_inst.put(frm[i], 2);
		repeat (30) @(negedge mclk);
		n0 = gaps;
		mbf_bus_node_inst.put(8'h00, 2);
		`CMP({gaps - n0 == 1, rx_result}, 9'h106, "late char");
		repeat (60) @(negedge mclk);
		`CMP({logq[4], logq[5], logq[6], logq[7]}, 32'hE6060000, "gap log");
		n0 = calls;
		send_frm(1'b0, 8'h00);
		repeat (CG + CR + 4) @(negedge mclk);
		`CMP({calls - n0 == 1, frm_len}, 9'h108, "buffer cleared");
		$display("test rtu_slave finished");
	endtask

	task automatic t_rtu_checks();
		logic [7:0] res [5] = '{8'h03, 8'h04, 8'h05, 8'h01, 8'h01};
		int n0;
		do_reset(1'b0, 1'b0);
		log_ready = 1'b0;
		for (int k = 0; k < 5; k++)
		begin
			n0 = calls;
			frm = '{k == 0 ? 8'h05 : 8'h01, k == 1 ? 8'h07 : 8'h03, 8'h00, 8'h00, 8'h00, 8'h02};
			send_frm(1'b0, k == 2 ? 8'h5A : 8'h00);
			repeat (CG + CR + 8) @(negedge mclk);
			`CMP({calls - n0 == 1, rx_result, frm_len}, {k > 2, res[k], 8'h08}, "check");
		end
		`CMP({log_valid, logq.size() == 0}, 2'h3, "log stalled");
		log_ready = 1'b1;
		repeat (40) @(negedge mclk);
		`CMP({log_valid, logq.size() == 20}, 2'h1, "log drained");
		for (int k = 0; k < 5; k++)
			`CMP({logq[4 * k], logq[4 * k + 1]}, {4'hA, res[k][3:0], 8'h08}, "log");
		$display("test rtu_checks finished");
	endtask

	task automatic t_ascii_slave();
		int n0;
		do_reset(1'b0, 1'b1);
		n0 = calls;
		frm = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
		send_frm(1'b1, 8'h00);
		repeat (6) @(negedge mclk);
		`CMP({calls - n0 == 1, rx_result, frm_len}, 17'h10107, "ascii frame");
		n0 = gaps;
		mbf_bus_node_inst.put(8'h3A, 2);
		mbf_bus_node_inst.put(8'h30, 2);
		mbf_bus_node_inst.put(8'h31, 0);
		repeat (AG + 4) @(negedge mclk);
		`CMP({gaps - n0 == 1, rx_result}, 9'h106, "ascii gap");
		n0 = calls;
		frm = '{8'h01};
		send_frm(1'b1, 8'h00);
		repeat (6) @(negedge mclk);
		`CMP({calls - n0 == 0, rx_result, frm_len}, 17'h10702, "short frame");
		$display("test ascii_slave finished");
	endtask

	task automatic t_master(input logic a);
		int n, n0, t0;
		do_reset(1'b1, a);
		slow = 1'b1;
		mbf_bus_node_inst.tx_seen.delete();
		n = 0;
		while (!tx_valid && n < 600)
		begin
			@(negedge mclk);
			n++;
		end
		t0 = cyc;
		frm = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10};
		mk_wire(a);
		repeat (100) @(negedge mclk);
		`CMP(mbf_bus_node_inst.tx_seen.size(), wire_q.size(), "poll size");
		foreach (wire_q[i]) `CMP(mbf_bus_node_inst.tx_seen[i], wire_q[i], "poll");
		n0 = calls;
		frm = '{8'h01, 8'h01, 8'h02, 8'hFF, 8'hFF};
		send_frm(a, 8'h00);
		repeat (CG + CR + 6) @(negedge mclk);
		`CMP({calls - n0 == 1, rx_result}, 9'h101, "response");
		`CMP({logq[0], logq[2], logq[3], logq[4]}, 32'hB10101A1, "tx log");
		`CMP(logq[1], a ? 8'h11 : 8'h08, "tx log length");
		frm = '{8'h01, 8'h81, 8'h02};
		send_frm(a, 8'h00);
		repeat (CG + CR + 6) @(negedge mclk);
		`CMP({calls - n0 == 1, rx_result}, 9'h108, "error response");
		n = 0;
		while (!tx_valid && n < 600)
		begin
			@(negedge mclk);
			n++;
		end
		`CMP(cyc - t0, PC, "poll period");
		slow = 1'b0;
		$display("test master finished");
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		nrst = 1'b0;
		cfg_master = 1'b0;
		cfg_ascii = 1'b0;
		node_addr = 8'h01;
		frm_rd_idx = 8'h00;
		log_ready = 1'b1;
		slow = 1'b0;
		t_rtu_slave();
		t_rtu_checks();
		t_ascii_slave();
		t_master(1'b0);
		t_master(1'b1);
		end_sim();
	end
	// cut a hang well past the few thousand cycles the scenarios need
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		$display("unexpected %0t watchdog", $time);
		end_sim();
	end
endmodule // mbf_framer_bench
